// ===== hw/mpg_port.sv
`timescale 1ns/1ps
// Notes on behaviour
// - All sixteen lines form one data word; reads give levels, writes set outputs.
// - Data group is bits 0-7, select group bits 8-15, each a byte.
// - Direction bit sits at the same position in the other space's word.
// - On-chip direction is per line; external buffers switch per byte.
// - Reset: data lines non-inverting inputs, select lines outputs driving zero.
// - PC variant buffer word: bit 4 data byte, bit 5 select byte.
// - VME variant buffer word: bit 0 data byte, bit 1 select byte.
// - Each line may be inverting or non-inverting.
// - Inversion word holds one bit per line; 1 means inverting.
// - Reset clears every inversion bit.
// - Function-select word picks general use or alternate channel per line.
// - Reset sets every line to general-purpose use.
// - In multiplexed accessory mode the port drives select, and data on writes, itself, except on lines set to alternate use.
module mpg_port #(
  parameter mpg_pkg::mpg_variant_t VARIANT    = mpg_pkg::MPG_VARIANT_PC,
  parameter int unsigned           SETTLE_CYC = mpg_pkg::MUX_SETTLE_CYC
) (
  // Clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        ce,
  // Processor word access
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_space_x,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [15:0] bus_wdata,
  output logic      [15:0] bus_rdata,
  output logic             bus_rvalid,
  // Port lines
  input  wire logic [15:0] line_in,
  output logic      [15:0] line_out,
  output logic      [15:0] line_oe,
  // External buffer direction
  output logic             buf_dir_data,
  output logic             buf_dir_select,
  // Alternate channel connections
  input  wire logic [15:0] alt_out,
  input  wire logic [15:0] alt_oe,
  output logic      [15:0] alt_in,
  // Multiplexed accessory mode
  input  wire logic        mux_auto_en,
  input  wire logic        mux_req,
  input  wire logic        mux_wr,
  input  wire logic [7:0]  mux_sel_byte,
  input  wire logic [7:0]  mux_wr_byte,
  output logic             mux_busy,
  output logic             mux_done,
  output logic      [7:0]  mux_rd_byte
);

  localparam int unsigned DL = mpg_pkg::DATA_LSB;
  localparam int unsigned SL = mpg_pkg::SELECT_LSB;
  localparam int unsigned GW = mpg_pkg::GROUP_WIDTH;

  // Register state
  logic [15:0] line_data_reg;
  logic [15:0] line_dir_reg;
  logic [15:0] line_inv_reg;
  logic [15:0] line_fsel_reg;
  logic [5:0]  buf_pc_reg;
  logic [1:0]  buf_vme_reg;

  // Pin synchroniser
  logic [15:0] line_meta_reg;
  logic [15:0] line_sync_reg;
  logic [15:0] line_level;

  // Address decode
  logic hit_word;
  logic hit_ctrl;
  logic hit_pc;
  logic hit_vme;
  logic wr_ce;
  logic rd_ce;

  // Accessory sequencer channel
  mpg_mux_if mx ();
  logic [15:0] auto_val;
  logic [15:0] auto_oe;
  logic        auto_en;

  assign hit_word = (bus_addr == mpg_pkg::ADDR_LINE_WORD);
  assign hit_ctrl = (bus_addr == mpg_pkg::ADDR_LINE_CTRL);
  assign hit_pc   = (bus_addr == mpg_pkg::ADDR_BUF_DIR_PC) && !bus_space_x;
  assign hit_vme  = (bus_addr == mpg_pkg::ADDR_BUF_DIR_VME) && !bus_space_x;
  assign wr_ce    = bus_wr && ce;
  assign rd_ce    = bus_rd && ce;

  // Two stages before any logic sees a pin
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      line_meta_reg <= 16'h0000;
      line_sync_reg <= 16'h0000;
    end else if (ce) begin
      line_meta_reg <= line_in;
      line_sync_reg <= line_meta_reg;
    end
  end

  // Data word in Y space
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      line_data_reg <= mpg_pkg::RST_LINE_DATA;
    end else if (wr_ce && hit_word && !bus_space_x) begin
      line_data_reg <= bus_wdata;
    end
  end

  // Direction word in X space, same offset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      line_dir_reg <= mpg_pkg::RST_LINE_DIR;
    end else if (wr_ce && hit_word && bus_space_x) begin
      // Per-line storage; byte-uniform values are software's duty
      line_dir_reg <= bus_wdata;
    end
  end

  // Inversion word in X space
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      line_inv_reg <= mpg_pkg::RST_LINE_INV;
    end else if (wr_ce && hit_ctrl && bus_space_x) begin
      line_inv_reg <= bus_wdata;
    end
  end

  // Function-select word in Y space
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      line_fsel_reg <= mpg_pkg::RST_LINE_FSEL;
    end else if (wr_ce && hit_ctrl && !bus_space_x) begin
      line_fsel_reg <= bus_wdata;
    end
  end

  // Buffer-direction words; low PC bits belong to other ports
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      buf_pc_reg  <= mpg_pkg::RST_BUF_DIR_PC;
      buf_vme_reg <= mpg_pkg::RST_BUF_DIR_VME;
    end else if (wr_ce) begin
      if (hit_pc) begin
        buf_pc_reg <= bus_wdata[mpg_pkg::PC_BUF_WIDTH-1:0];
      end
      if (hit_vme) begin
        buf_vme_reg <= bus_wdata[mpg_pkg::VME_BUF_WIDTH-1:0];
      end
    end
  end

  // Only the fitted variant's word steers the buffers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      buf_dir_data   <= 1'b0;
      buf_dir_select <= 1'b1;
    end else if (ce) begin
      if (VARIANT == mpg_pkg::MPG_VARIANT_VME) begin
        buf_dir_data   <= buf_vme_reg[mpg_pkg::VME_BUF_DATA_BIT];
        buf_dir_select <= buf_vme_reg[mpg_pkg::VME_BUF_SELECT_BIT];
      end else begin
        buf_dir_data   <= buf_pc_reg[mpg_pkg::PC_BUF_DATA_BIT];
        buf_dir_select <= buf_pc_reg[mpg_pkg::PC_BUF_SELECT_BIT];
      end
    end
  end

  // Read path, answer one cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus_rdata  <= 16'h0000;
      bus_rvalid <= 1'b0;
    end else if (ce) begin
      bus_rvalid <= bus_rd;
      if (rd_ce) begin
        if (hit_word && !bus_space_x) begin
          bus_rdata <= line_level;
        end else if (hit_word) begin
          bus_rdata <= line_dir_reg;
        end else if (hit_ctrl && bus_space_x) begin
          bus_rdata <= line_inv_reg;
        end else if (hit_ctrl) begin
          bus_rdata <= line_fsel_reg;
        end else if (hit_pc) begin
          bus_rdata <= {10'h000, buf_pc_reg};
        end else if (hit_vme) begin
          bus_rdata <= {14'h0000, buf_vme_reg};
        end else begin
          // Unmapped words read as zero
          bus_rdata <= 16'h0000;
        end
      end
    end
  end

  // Alternate channels see corrected line levels
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      alt_in <= 16'h0000;
    end else if (ce) begin
      alt_in <= line_level;
    end
  end

  // Accessory mode: select byte driven, data byte read back
  assign auto_en     = mux_auto_en;
  assign mx.req      = mux_req && mux_auto_en;
  assign mx.wr       = mux_wr;
  assign mx.sel_byte = mux_sel_byte;
  assign mx.wr_byte  = mux_wr_byte;
  assign mx.dat_in   = line_level[DL +: GW];
  assign mux_busy    = mx.busy;
  assign mux_done    = mx.done;
  assign mux_rd_byte = mx.rd_byte;

  assign auto_val = {mx.sel_out, mx.dat_out};
  assign auto_oe  = {{GW{1'b1}}, {GW{mx.drive_dat}}};

  mpg_mux_seq #(
    .SETTLE_CYC (SETTLE_CYC)
  ) u_seq (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .mx      (mx)
  );

  // One cell per line; select cells come out of reset driving
  genvar g;
  generate
    for (g = 0; g < mpg_pkg::LINE_COUNT; g++) begin : g_line
      mpg_line_cell #(
        .RESET_OE ((g >= SL) ? 1'b1 : 1'b0)
      ) u_cell (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .ce          (ce),
        .dir_bit     (line_dir_reg[g]),
        .inv_bit     (line_inv_reg[g]),
        .fsel_bit    (line_fsel_reg[g]),
        .gp_val      (line_data_reg[g]),
        .auto_en     (auto_en),
        .auto_oe     (auto_oe[g]),
        .auto_val    (auto_val[g]),
        .alt_val     (alt_out[g]),
        .alt_oe      (alt_oe[g]),
        .pin_level   (line_sync_reg[g]),
        .pin_o       (line_out[g]),
        .pin_oe      (line_oe[g]),
        .logic_level (line_level[g])
      );
    end
  endgenerate

endmodule : mpg_port

// ===== hw/mpg_pkg.sv
package mpg_pkg;

  // Port geometry
  localparam int unsigned LINE_COUNT  = 16;
  localparam int unsigned GROUP_WIDTH = 8;
  localparam int unsigned DATA_LSB    = 0;
  localparam int unsigned SELECT_LSB  = 8;

  // Word addresses; X and Y spaces share offsets
  localparam logic [15:0] ADDR_LINE_WORD   = 16'hC082;
  localparam logic [15:0] ADDR_LINE_CTRL   = 16'hC086;
  localparam logic [15:0] ADDR_BUF_DIR_PC  = 16'hE800;
  localparam logic [15:0] ADDR_BUF_DIR_VME = 16'hE802;

  // Buffer-direction field positions
  localparam int unsigned PC_BUF_DATA_BIT    = 4;
  localparam int unsigned PC_BUF_SELECT_BIT  = 5;
  localparam int unsigned VME_BUF_DATA_BIT   = 0;
  localparam int unsigned VME_BUF_SELECT_BIT = 1;
  localparam int unsigned PC_BUF_WIDTH       = 6;
  localparam int unsigned VME_BUF_WIDTH      = 2;

  // Reset values
  localparam logic [15:0] RST_LINE_DATA   = 16'h0000;
  localparam logic [15:0] RST_LINE_DIR    = 16'hFF00;
  localparam logic [15:0] RST_LINE_INV    = 16'h0000;
  localparam logic [15:0] RST_LINE_FSEL   = 16'h0000;
  localparam logic [5:0]  RST_BUF_DIR_PC  = 6'h20;
  localparam logic [1:0]  RST_BUF_DIR_VME = 2'h2;

  // Multiplexed accessory settle time
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned MUX_SETTLE_NS  = 1000;
  localparam int unsigned MUX_SETTLE_CYC =
    (MUX_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic {
    MPG_VARIANT_PC,
    MPG_VARIANT_VME
  } mpg_variant_t;

endpackage : mpg_pkg

// ===== hw/mpg_mux_if.sv
`timescale 1ns/1ps
interface mpg_mux_if;
  logic       req;
  logic       wr;
  logic [7:0] sel_byte;
  logic [7:0] wr_byte;
  logic       busy;
  logic       done;
  logic [7:0] rd_byte;
  logic       drive_dat;
  logic [7:0] sel_out;
  logic [7:0] dat_out;
  logic [7:0] dat_in;

  modport seq (
    input  req, wr, sel_byte, wr_byte, dat_in,
    output busy, done, rd_byte, drive_dat, sel_out, dat_out
  );
  modport port (
    output req, wr, sel_byte, wr_byte, dat_in,
    input  busy, done, rd_byte, drive_dat, sel_out, dat_out
  );
endinterface : mpg_mux_if

// ===== hw/mpg_line_cell.sv
`timescale 1ns/1ps
module mpg_line_cell #(
  parameter logic RESET_OE = 1'b0
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic ce,
  // Configuration
  input  wire logic dir_bit,
  input  wire logic inv_bit,
  input  wire logic fsel_bit,
  // Sources
  input  wire logic gp_val,
  input  wire logic auto_en,
  input  wire logic auto_oe,
  input  wire logic auto_val,
  input  wire logic alt_val,
  input  wire logic alt_oe,
  // Pin side
  input  wire logic pin_level,
  output logic      pin_o,
  output logic      pin_oe,
  output logic      logic_level
);

  // Inversion applies to both directions, but not to alternate-channel outputs
  assign logic_level = pin_level ^ inv_bit;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_o  <= 1'b0;
      pin_oe <= RESET_OE;
    end else if (ce) begin
      if (fsel_bit) begin
        pin_o  <= alt_val;
        pin_oe <= alt_oe;
      end else if (auto_en) begin
        pin_o  <= auto_val ^ inv_bit;
        pin_oe <= auto_oe;
      end else begin
        pin_o  <= gp_val ^ inv_bit;
        pin_oe <= dir_bit;
      end
    end
  end

endmodule : mpg_line_cell

// ===== hw/mpg_mux_seq.sv
`timescale 1ns/1ps
module mpg_mux_seq #(
  parameter int unsigned SETTLE_CYC = mpg_pkg::MUX_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic ce,
  // Transfer channel
  mpg_mux_if.seq    mx
);

  typedef enum logic [1:0] {
    MPG_SEQ_IDLE,
    MPG_SEQ_SETTLE,
    MPG_SEQ_DONE
  } mpg_seq_state_t;

  mpg_seq_state_t state_reg;
  logic [15:0]    cnt_reg;
  logic           wr_reg;

  assign mx.busy = (state_reg != MPG_SEQ_IDLE);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg    <= MPG_SEQ_IDLE;
      cnt_reg      <= 16'h0000;
      wr_reg       <= 1'b0;
      mx.sel_out   <= 8'h00;
      mx.dat_out   <= 8'h00;
      mx.drive_dat <= 1'b0;
      mx.rd_byte   <= 8'h00;
      mx.done      <= 1'b0;
    end else if (ce) begin
      mx.done <= 1'b0;
      case (state_reg)
        MPG_SEQ_IDLE: begin
          if (mx.req) begin
            // Select and data together, then let the accessory settle
            mx.sel_out   <= mx.sel_byte;
            mx.dat_out   <= mx.wr_byte;
            mx.drive_dat <= mx.wr;
            wr_reg       <= mx.wr;
            cnt_reg      <= 16'(SETTLE_CYC);
            state_reg    <= MPG_SEQ_SETTLE;
          end
        end
        MPG_SEQ_SETTLE: begin
          if (cnt_reg <= 16'h0001) begin
            if (!wr_reg) begin
              mx.rd_byte <= mx.dat_in;
            end
            state_reg <= MPG_SEQ_DONE;
          end else begin
            cnt_reg <= cnt_reg - 16'h0001;
          end
        end
        MPG_SEQ_DONE: begin
          mx.drive_dat <= 1'b0;
          mx.done      <= 1'b1;
          state_reg    <= MPG_SEQ_IDLE;
        end
        default: begin
          state_reg <= MPG_SEQ_IDLE;
        end
      endcase
    end
  end

endmodule : mpg_mux_seq

// ===== test/mpg_port_asserts.sv
`timescale 1ns/1ps
module mpg_port_asserts #(
  parameter int unsigned SETTLE_CYC = 2
) (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        ce,
  // Register access
  input wire logic [15:0] bus_addr,
  input wire logic        bus_space_x,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata,
  input wire logic        bus_rvalid,
  // Pins
  input wire logic [15:0] line_oe,
  input wire logic        buf_dir_data,
  // Accessory
  input wire logic        mux_auto_en,
  input wire logic        mux_req,
  input wire logic        mux_busy,
  input wire logic        mux_done
);
  localparam int DONE_DLY = SETTLE_CYC + 2;
  logic [15:0] fsel_reg;
  logic        rd_t;
  logic        wy;
  logic        wx;
  logic        wd4;
  logic        mapped;
  logic        take;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  assign rd_t = bus_rd && ce;
  assign wy = bus_wr && ce && !bus_space_x;
  assign wx = bus_wr && ce && bus_space_x;
  assign wd4 = bus_wdata[4];
  assign take = mux_req && mux_auto_en && !mux_busy && ce;
  assign mapped = bus_addr == 16'hC082 || bus_addr == 16'hC086 ||
    (!bus_space_x && (bus_addr == 16'hE800 || bus_addr == 16'hE802));
  // Alternate use overrides direction, so track it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) fsel_reg <= 16'h0000;
    else if (wy && bus_addr == 16'hC086) fsel_reg <= bus_wdata;
  end
  rvalid_one_a: assert property (rd_t |=> bus_rvalid)
    else $error("read gave no valid");
  rdata_hold_a: assert property (!bus_rvalid |-> $stable(bus_rdata))
    else $error("read data moved without valid");
  unmapped_zero_a: assert property (
    rd_t && !mapped |=> bus_rdata == 16'h0000)
    else $error("unmapped read not zero");
  buf_data_a: assert property (
    wy && bus_addr == 16'hE800 |-> ##2 buf_dir_data == $past(wd4, 2))
    else $error("data buffer direction wrong");
  dir_oe_a: assert property (
    wx && bus_addr == 16'hC082 && fsel_reg == 16'h0000 && !mux_auto_en
    |-> ##2 line_oe == $past(bus_wdata, 2))
    else $error("line enables differ from direction");
  mux_done_a: assert property (take |-> ##DONE_DLY mux_done)
    else $error("transfer done late or missing");
  mux_busy_a: assert property (
    take |=> (mux_busy && !mux_done) [*3])
    else $error("busy dropped early");
  done_single_a: assert property (mux_done |=> !mux_done)
    else $error("done longer than one cycle");
  cover property (mux_done);
  cover property (rd_t && !mapped);
  cover property (wy && bus_addr == 16'hE800);
endmodule : mpg_port_asserts

bind mpg_port mpg_port_asserts #(.SETTLE_CYC(SETTLE_CYC)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .ce(ce), .bus_addr(bus_addr),
  .bus_space_x(bus_space_x), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
  .line_oe(line_oe), .buf_dir_data(buf_dir_data),
  .mux_auto_en(mux_auto_en), .mux_req(mux_req), .mux_busy(mux_busy),
  .mux_done(mux_done)
);

// ===== test/mpg_field_model.sv
`timescale 1ns/1ps
module mpg_field_model (
  // Device pins
  input  wire logic [15:0] line_out,
  input  wire logic [15:0] line_oe,
  output logic      [15:0] line_in,
  // Field side
  input  wire logic        acc_en,
  input  wire logic [15:0] ext_val
);
  logic [15:0] far;
  // Board answers the select byte with its inverse on the data byte
  assign far = acc_en ? {ext_val[15:8], ~line_out[15:8]} : ext_val;
  // Device drive wins; field drives every released line
  assign line_in = (line_oe & line_out) | (~line_oe & far);
endmodule : mpg_field_model

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
  logic        clk_sys, rst, bus_space_x, bus_wr, bus_rd, bus_rvalid;
  logic        buf_dir_data, buf_dir_select, acc_en, ce;
  logic        mux_auto_en, mux_req, mux_wr, mux_busy, mux_done;
  logic [15:0] bus_addr, bus_wdata, bus_rdata, line_in, line_out, line_oe;
  logic [15:0] alt_out, alt_oe, alt_in, ext_val;
  logic [7:0]  mux_sel_byte, mux_wr_byte, mux_rd_byte;
  int          n_errors, n_compared, cyc;

  // Settle count must outlast the two-stage pin sync plus pin launch
  mpg_port #(.SETTLE_CYC(4)) dut (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .bus_addr(bus_addr),
    .bus_space_x(bus_space_x), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
    .line_in(line_in), .line_out(line_out), .line_oe(line_oe),
    .buf_dir_data(buf_dir_data), .buf_dir_select(buf_dir_select),
    .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in),
    .mux_auto_en(mux_auto_en), .mux_req(mux_req), .mux_wr(mux_wr),
    .mux_sel_byte(mux_sel_byte), .mux_wr_byte(mux_wr_byte),
    .mux_busy(mux_busy), .mux_done(mux_done), .mux_rd_byte(mux_rd_byte));
  mpg_field_model u_field (.line_out(line_out), .line_oe(line_oe),
    .line_in(line_in), .acc_en(acc_en), .ext_val(ext_val));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  task automatic chk(string w, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask : chk

  task automatic wr(logic x, logic [15:0] a, logic [15:0] d);
    @(posedge clk_sys);
    bus_wr <= 1'b1;
    bus_space_x <= x;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask : wr

  task automatic rd(logic x, logic [15:0] a, logic [15:0] e, string w);
    @(posedge clk_sys);
    bus_rd <= 1'b1;
    bus_space_x <= x;
    bus_addr <= a;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    #1;
    chk(w, e, bus_rdata);
    chk("rvalid", 16'h0001, {15'h0000, bus_rvalid});
  endtask : rd

  task automatic xfer(logic w, logic [7:0] s, logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    mux_req <= 1'b1;
    mux_wr <= w;
    mux_sel_byte <= s;
    mux_wr_byte <= d;
    @(posedge clk_sys);
    mux_sel_byte <= ~s;
    @(posedge clk_sys);
    mux_req <= 1'b0;
    #1;
    chk("datoe", w ? 16'h00FF : 16'h0000, line_oe & 16'h00FF);
    if (w) chk("dat", {8'h00, d}, line_out & 16'h00FF);
    while (!mux_done && k < 20) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    chk("done", 16'h0001, {15'h0000, mux_done});
    repeat (8) @(posedge clk_sys);
    #1;
    chk("sel", {s, 8'h00}, line_out & 16'hFF00);
  endtask : xfer

  task automatic t_reset;
    rd(1'b1, 16'hC082, 16'hFF00, "dir");
    rd(1'b1, 16'hC086, 16'h0000, "inv");
    rd(1'b0, 16'hC086, 16'h0000, "fsel");
    rd(1'b0, 16'hE800, 16'h0020, "pcbuf");
    rd(1'b0, 16'hE802, 16'h0002, "vmebuf");
    rd(1'b0, 16'hC082, 16'h00A5, "word");
    rd(1'b1, 16'hE800, 16'h0000, "xspace");
    rd(1'b0, 16'hC084, 16'h0000, "unmapped");
    chk("oe", 16'hFF00, line_oe);
    chk("out", 16'h0000, line_out);
    chk("buf", 16'h0002, {14'h0000, buf_dir_select, buf_dir_data});
    $display("test reset done");
  endtask : t_reset

  task automatic t_io;
    wr(1'b1, 16'hC082, 16'h00FF);
    wr(1'b0, 16'hE800, 16'h0010);
    wr(1'b0, 16'hE802, 16'h0001);
    wr(1'b1, 16'hC086, 16'h0F0F);
    wr(1'b0, 16'hC082, 16'h1234);
    repeat (4) @(posedge clk_sys);
    #1;
    chk("oe", 16'h00FF, line_oe);
    chk("out", 16'h003B, line_out & 16'h00FF);
    chk("buf", 16'h0001, {14'h0000, buf_dir_select, buf_dir_data});
    rd(1'b0, 16'hE802, 16'h0001, "vmebuf");
    rd(1'b0, 16'hC082, 16'hCC34, "word");
    wr(1'b1, 16'hC082, 16'h0003);
    repeat (3) @(posedge clk_sys);
    #1;
    chk("oe", 16'h0003, line_oe);
    $display("test io done");
  endtask : t_io

  task automatic t_fsel;
    wr(1'b1, 16'hC086, 16'h0000);
    wr(1'b0, 16'hC086, 16'h00F0);
    alt_out <= 16'h00A0;
    alt_oe <= 16'h00F0;
    repeat (5) @(posedge clk_sys);
    #1;
    chk("altoe", 16'h00F0, line_oe & 16'h00F0);
    chk("altout", 16'h00A0, line_out & 16'h00F0);
    chk("altin", 16'h00A0, alt_in & 16'h00F0);
    rd(1'b0, 16'hC086, 16'h00F0, "fsel");
    wr(1'b0, 16'hC086, 16'h0000);
    $display("test fsel done");
  endtask : t_fsel

  // Writes with the clock enable low must leave state untouched
  task automatic t_ce;
    ce <= 1'b0;
    wr(1'b1, 16'hC086, 16'hFFFF);
    ce <= 1'b1;
    rd(1'b1, 16'hC086, 16'h0000, "inv");
    $display("test ce done");
  endtask : t_ce

  task automatic t_mux;
    wr(1'b1, 16'hC082, 16'hFF00);
    wr(1'b0, 16'hE800, 16'h0020);
    mux_auto_en <= 1'b1;
    acc_en <= 1'b1;
    xfer(1'b1, 8'h5A, 8'h3C);
    xfer(1'b0, 8'h81, 8'h00);
    chk("rdbyte", 16'h007E, {8'h00, mux_rd_byte});
    $display("test mux done");
  endtask : t_mux

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      print_verdict();
    end
  end

  initial begin
    {rst, bus_space_x, bus_wr, bus_rd, acc_en} = 5'h10;
    {mux_auto_en, mux_req, mux_wr} = 3'h0;
    {bus_addr, bus_wdata, alt_out, alt_oe} = 64'h0;
    {mux_sel_byte, mux_wr_byte} = 16'h0000;
    ext_val = 16'hC3A5;
    ce = 1'b1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_io();
    t_fsel();
    t_ce();
    t_mux();
    print_verdict();
  end
endmodule : tb
